// ---- cltc_defs.vh ----
// constants for the cab load threshold controller
// assumes a single 20 MHz clock and plain-port configuration
`ifndef CLTC_DEFS_VH
`define CLTC_DEFS_VH
`define CLTC_CLK_HZ        20000000
`define CLTC_DEB_MS        10
`define CLTC_DEB_CYC       ((`CLTC_CLK_HZ / 1000) * `CLTC_DEB_MS)
`define CLTC_CD_SEC        5
// last blink half-period index of one second (four per second)
`define CLTC_SEC_LAST      3'h3
`define CLTC_BLINK_MS      250
`define CLTC_BLINK_CYC     ((`CLTC_CLK_HZ / 1000) * `CLTC_BLINK_MS)
`define CLTC_DBL_MS        1000
`define CLTC_DBL_CYC       ((`CLTC_CLK_HZ / 1000) * `CLTC_DBL_MS)
// parameter indices in menu order
`define CLTC_P_ZERO        3'h0
`define CLTC_P_SPAN        3'h1
`define CLTC_P_CAP         3'h2
`define CLTC_P_OVL         3'h3
`define CLTC_P_AUX         3'h4
`define CLTC_P_LAST        3'h4
`define CLTC_RST_CAP       16'h0320
`define CLTC_RST_OVL       16'h03e8
`define CLTC_RST_AUX       16'h0190
`define CLTC_RST_SPAN      16'h01f4
`define CLTC_RST_SCALE     16'h0100
`define CLTC_SCALE_SH      8
`endif

// ---- cltc_cab_load_threshold_controller.v ----
// cab load weighing controller: load compute, relays, display, key menu, calibration
// assumes sensor samples and keys are asynchronous, one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "cltc_defs.vh"
module cltc_cab_load_threshold_controller #(
  parameter RAW_W   = 16,
  parameter SEG_N   = 8,
  parameter DEB_CYC = `CLTC_DEB_CYC,
  parameter BLK_CYC = `CLTC_BLINK_CYC,
  parameter DBL_CYC = `CLTC_DBL_CYC,
  parameter CD_SEC  = `CLTC_CD_SEC
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [RAW_W-1:0] sensor_raw,
  input  wire             hold_in,
  input  wire             key_menu,
  input  wire             key_select,
  input  wire             key_modify,
  output reg              capacity_relay_no,
  output reg              capacity_relay_nc,
  output reg              overload_relay_no,
  output reg              overload_relay_nc,
  output reg              auxiliary_relay_no,
  output reg              auxiliary_relay_nc,
  output reg  [SEG_N-1:0] figure_seg,
  output reg              kg_lamp,
  output reg              buzzer,
  output reg  [2:0]       disp_param,
  output reg  [15:0]      disp_value,
  output reg              disp_editing,
  output reg  [1:0]       disp_digit,
  output reg              disp_digit_on,
  output reg              disp_weight_mode,
  output reg              disp_blank
);

  localparam ST_IDLE = 4'h1;
  localparam ST_EDIT = 4'h2;
  localparam ST_ARM  = 4'h4;
  localparam ST_CD   = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins and sensor word
  reg [RAW_W-1:0] raw_s1_q, raw_s2_q;
  reg [3:0]       pin_s1_q, pin_s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1_q <= {RAW_W{1'b0}};
      raw_s2_q <= {RAW_W{1'b0}};
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      raw_s1_q <= sensor_raw;
      raw_s2_q <= raw_s1_q;
      pin_s1_q <= {hold_in, key_modify, key_select, key_menu};
      pin_s2_q <= pin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // key debounce: state accepted only after stable for DEB_CYC
  reg [2:0]  key_st_q;
  reg [2:0]  key_prev_q;
  reg [31:0] deb_cnt_q [0:2];
  wire [2:0] key_rise = key_st_q & ~key_prev_q;
  integer k;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_st_q   <= 3'h0;
      key_prev_q <= 3'h0;
      for (k = 0; k < 3; k = k + 1) deb_cnt_q[k] <= 32'h0;
    end else begin
      key_prev_q <= key_st_q;
      for (k = 0; k < 3; k = k + 1) begin
        if (pin_s2_q[k] == key_st_q[k]) begin
          deb_cnt_q[k] <= 32'h0;
        end else if (deb_cnt_q[k] >= DEB_CYC - 1) begin
          key_st_q[k]  <= pin_s2_q[k];
          deb_cnt_q[k] <= 32'h0;
        end else begin
          deb_cnt_q[k] <= deb_cnt_q[k] + 32'h1;
        end
      end
    end
  end
  wire menu_p = key_rise[0];
  wire sel_p  = key_rise[1];
  wire mod_p  = key_rise[2];
  wire hold_w = pin_s2_q[3];

  ////////////////////////////////////////////////////////////////////////
  // timebase: blink toggle and one-second tick share one counter
  reg [31:0] blk_cnt_q;
  reg        blink_q;
  reg [2:0]  sec_div_q;
  wire       blk_tick = (blk_cnt_q >= BLK_CYC - 1);
  wire       sec_tick = blk_tick && (sec_div_q == `CLTC_SEC_LAST);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt_q <= 32'h0;
      blink_q   <= 1'b0;
      sec_div_q <= 3'h0;
    end else if (blk_tick) begin
      blk_cnt_q <= 32'h0;
      blink_q   <= ~blink_q;
      sec_div_q <= (sec_div_q == `CLTC_SEC_LAST) ? 3'h0 : sec_div_q + 3'h1;
    end else begin
      blk_cnt_q <= blk_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stored parameters and measurement
  reg [15:0]      trip_cap_q, trip_ovl_q, trip_aux_q, span_ref_q, scale_q;
  reg [RAW_W-1:0] zero_q, meas_q;
  reg [15:0]      load_q;

  // bcd-free decimal digit edit: digit d of a 4-digit value incremented mod 10
  function [15:0] digit_bump;
    input [15:0] v;
    input [1:0]  d;
    reg   [15:0] p;
    reg   [15:0] dig;
    begin
      p   = (d == 2'h0) ? 16'h0001 : (d == 2'h1) ? 16'h000a :
            (d == 2'h2) ? 16'h0064 : 16'h03e8;
      dig = (v / p) % 16'h000a;
      digit_bump = (dig == 16'h0009) ? v - 16'h0009 * p : v + p;
    end
  endfunction

  function [15:0] stored_val;
    input [2:0] idx;
    begin
      case (idx)
        `CLTC_P_SPAN: stored_val = span_ref_q;
        `CLTC_P_CAP:  stored_val = trip_cap_q;
        `CLTC_P_OVL:  stored_val = trip_ovl_q;
        `CLTC_P_AUX:  stored_val = trip_aux_q;
        default:      stored_val = 16'h0000;
      endcase
    end
  endfunction

  wire [RAW_W-1:0] net_raw  = (meas_q > zero_q) ? meas_q - zero_q : {RAW_W{1'b0}};
  wire [31:0]      load_mul = net_raw * scale_q;

  ////////////////////////////////////////////////////////////////////////
  // menu / edit / calibration state machine
  reg [3:0]  st_q;
  reg [2:0]  par_q;
  reg [15:0] edit_q;
  reg [1:0]  dig_q;
  reg        menu_once_q;
  reg [31:0] dbl_cnt_q;
  reg [3:0]  cd_q;
  reg        cd_span_q;
  wire [15:0] span_raw = (raw_s2_q > zero_q) ? raw_s2_q - zero_q : 16'h0001;
  wire [31:0] cd_init  = CD_SEC;
  // divide in 32 bits so the shifted reference keeps its top bits
  // limitation: a quotient above 16 bits wraps, so span load must not be tiny
  wire [31:0] span_num = {16'h0000, span_ref_q} << `CLTC_SCALE_SH;
  wire [31:0] span_quo = span_num / {16'h0000, span_raw};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= ST_IDLE;
      par_q       <= `CLTC_P_ZERO;
      edit_q      <= 16'h0000;
      dig_q       <= 2'h0;
      menu_once_q <= 1'b0;
      dbl_cnt_q   <= 32'h0;
      cd_q        <= 4'h0;
      cd_span_q   <= 1'b0;
      trip_cap_q  <= `CLTC_RST_CAP;
      trip_ovl_q  <= `CLTC_RST_OVL;
      trip_aux_q  <= `CLTC_RST_AUX;
      span_ref_q  <= `CLTC_RST_SPAN;
      scale_q     <= `CLTC_RST_SCALE;
      zero_q      <= {RAW_W{1'b0}};
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (menu_p) begin
            par_q <= (par_q == `CLTC_P_LAST) ? `CLTC_P_ZERO : par_q + 3'h1;
          end else if (sel_p) begin
            dig_q       <= 2'h0;
            menu_once_q <= 1'b0;
            edit_q      <= stored_val(par_q);
            st_q        <= (par_q == `CLTC_P_ZERO) ? ST_ARM : ST_EDIT;
          end
        end
        ST_ARM: begin
          if (menu_p) begin
            cd_q      <= cd_init[3:0];
            cd_span_q <= 1'b0;
            st_q      <= ST_CD;
          end
        end
        ST_EDIT: begin
          if (menu_once_q && dbl_cnt_q >= DBL_CYC - 1) begin
            menu_once_q <= 1'b0;
            st_q        <= ST_IDLE;
          end else if (menu_once_q) begin
            dbl_cnt_q <= dbl_cnt_q + 32'h1;
          end
          if (sel_p) begin
            dig_q <= dig_q + 2'h1;
          end else if (mod_p) begin
            edit_q <= digit_bump(edit_q, dig_q);
          end else if (menu_p && menu_once_q) begin
            menu_once_q <= 1'b0;
            case (par_q)
              `CLTC_P_SPAN: begin
                span_ref_q <= edit_q;
                cd_q       <= cd_init[3:0];
                cd_span_q  <= 1'b1;
                st_q       <= ST_CD;
              end
              `CLTC_P_CAP: begin
                trip_cap_q <= edit_q;
                par_q      <= `CLTC_P_OVL;
                st_q       <= ST_IDLE;
              end
              `CLTC_P_OVL: begin
                trip_ovl_q <= edit_q;
                par_q      <= `CLTC_P_AUX;
                st_q       <= ST_IDLE;
              end
              default: begin
                trip_aux_q <= edit_q;
                par_q      <= `CLTC_P_ZERO;
                st_q       <= ST_IDLE;
              end
            endcase
          end else if (menu_p) begin
            menu_once_q <= 1'b1;
            dbl_cnt_q   <= 32'h0;
          end
        end
        ST_CD: begin
          if (sec_tick) begin
            if (cd_q == 4'h1) begin
              st_q <= ST_IDLE;
              if (cd_span_q) begin
                scale_q <= span_quo[15:0];
                par_q   <= `CLTC_P_CAP;
              end else begin
                zero_q <= raw_s2_q;
                par_q  <= `CLTC_P_SPAN;
              end
            end else begin
              cd_q <= cd_q - 4'h1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement, relays, figure and display drive
  integer s;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_q             <= {RAW_W{1'b0}};
      load_q             <= 16'h0000;
      capacity_relay_no  <= 1'b0;
      capacity_relay_nc  <= 1'b1;
      overload_relay_no  <= 1'b0;
      overload_relay_nc  <= 1'b1;
      auxiliary_relay_no <= 1'b0;
      auxiliary_relay_nc <= 1'b1;
      figure_seg         <= {SEG_N{1'b0}};
      kg_lamp            <= 1'b0;
      buzzer             <= 1'b0;
      disp_param         <= `CLTC_P_ZERO;
      disp_value         <= 16'h0000;
      disp_editing       <= 1'b0;
      disp_digit         <= 2'h0;
      disp_digit_on      <= 1'b1;
      disp_weight_mode   <= 1'b1;
      disp_blank         <= 1'b0;
    end else begin
      if (!hold_w) meas_q <= raw_s2_q;
      load_q <= load_mul[`CLTC_SCALE_SH+15:`CLTC_SCALE_SH];
      capacity_relay_no  <= (load_q > trip_cap_q);
      capacity_relay_nc  <= ~(load_q > trip_cap_q);
      overload_relay_no  <= (load_q > trip_ovl_q);
      overload_relay_nc  <= ~(load_q > trip_ovl_q);
      auxiliary_relay_no <= (load_q > trip_aux_q);
      auxiliary_relay_nc <= ~(load_q > trip_aux_q);
      for (s = 0; s < SEG_N; s = s + 1)
        figure_seg[s] <= (load_q >= trip_cap_q) ||
                         ({16'h0000, load_q} * SEG_N > {16'h0000, trip_cap_q} * s);
      kg_lamp <= (load_q >= trip_ovl_q);
      buzzer  <= (load_q >= trip_ovl_q);
      disp_param       <= par_q;
      disp_editing     <= (st_q == ST_EDIT);
      disp_digit       <= dig_q;
      disp_digit_on    <= (st_q == ST_EDIT) ? blink_q : 1'b1;
      disp_weight_mode <= (st_q == ST_IDLE) || (st_q == ST_ARM);
      disp_blank       <= (st_q == ST_IDLE) && hold_w && blink_q;
      disp_value       <= (st_q == ST_EDIT) ? edit_q :
                          (st_q == ST_CD)   ? {12'h000, cd_q} : load_q;
    end
  end

endmodule // cltc_cab_load_threshold_controller
`default_nettype wire

// ---- cltc_chk_assertions.sv ----
// port checker for the cab load threshold controller
// assumes one clock, reset async active low
`timescale 1ns/1ps
`default_nettype none
module cltc_chk #(parameter SEG_N = 8) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             hold_in,
  input wire logic             capacity_relay_no,
  input wire logic             capacity_relay_nc,
  input wire logic             overload_relay_no,
  input wire logic             overload_relay_nc,
  input wire logic             auxiliary_relay_no,
  input wire logic             auxiliary_relay_nc,
  input wire logic [SEG_N-1:0] figure_seg,
  input wire logic             kg_lamp,
  input wire logic             buzzer,
  input wire logic [2:0]       disp_param,
  input wire logic             disp_editing,
  input wire logic             disp_digit_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cap_contacts: assert property (capacity_relay_nc == !capacity_relay_no) else $error("cap contacts");
  a_ovl_contacts: assert property (overload_relay_nc == !overload_relay_no) else $error("ovl contacts");
  a_aux_contacts: assert property (auxiliary_relay_nc == !auxiliary_relay_no) else $error("aux contacts");
  a_kg_buzz: assert property (kg_lamp == buzzer) else $error("lamp and buzzer differ");
  a_ovl_lamp: assert property (overload_relay_no |-> kg_lamp) else $error("lamp off past overload");
  a_full_figure: assert property (capacity_relay_no |-> &figure_seg) else $error("figure not full");
  a_figure_fill: assert property ((figure_seg & (figure_seg + 1'b1)) == '0) else $error("figure gap");
  a_hold_freeze: assert property (hold_in [*8] |=> $stable({capacity_relay_no, overload_relay_no,
    auxiliary_relay_no})) else $error("relay moved in hold");
  a_menu_step: assert property ($changed(disp_param) |->
    disp_param == (($past(disp_param) == 3'h4) ? 3'h0 : $past(disp_param) + 3'h1))
    else $error("bad parameter step");
  a_idle_digit: assert property (!disp_editing |-> disp_digit_on) else $error("idle blink");
  c_trip: cover property ($rose(overload_relay_no));
  c_commit: cover property ($fell(disp_editing) ##1 $changed(disp_param));
  c_hold: cover property (hold_in [*8]);
endmodule // cltc_chk
////////////////////////////////////////////////////////////////
bind cltc_cab_load_threshold_controller cltc_chk #(.SEG_N(SEG_N)) chk_u (.clk(clk), .rst_n(rst_n),
  .hold_in(hold_in), .capacity_relay_no(capacity_relay_no), .capacity_relay_nc(capacity_relay_nc),
  .overload_relay_no(overload_relay_no), .overload_relay_nc(overload_relay_nc),
  .auxiliary_relay_no(auxiliary_relay_no), .auxiliary_relay_nc(auxiliary_relay_nc),
  .figure_seg(figure_seg), .kg_lamp(kg_lamp), .buzzer(buzzer), .disp_param(disp_param),
  .disp_editing(disp_editing), .disp_digit_on(disp_digit_on));
`default_nettype wire

// ---- cltc_cab_side_model.sv ----
// load sensor and door side model, reads relay contacts
// assumes the bench sets the wanted load and door state
`timescale 1ns/1ps
`default_nettype none
module cltc_cab_side_model (
  input  wire logic        clk,
  input  wire logic [15:0] load_set,
  input  wire logic        hold_set,
  input  wire logic [2:0]  rel_no,
  input  wire logic [2:0]  rel_nc,
  output var  logic [15:0] sensor_raw,
  output var  logic        hold_in,
  output wire logic [2:0]  contact_ok
);
  initial begin
    sensor_raw = 16'h0000;
    hold_in = 1'b0;
  end
  // word changes whole on one edge, never mid-sync
  always @(posedge clk) begin
    sensor_raw <= load_set;
    hold_in <= hold_set;
  end
  assign contact_ok = rel_no ^ rel_nc;
endmodule // cltc_cab_side_model
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the cab load threshold controller
// assumes shortened debounce, blink, double-press and countdown counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  keys = 3'h0;
  logic [15:0] load_set = 16'h0000;
  logic        hold_set = 1'b0;
  wire  [15:0] raw, val;
  wire         hold, cap_no, cap_nc, ovl_no, ovl_nc, aux_no, aux_nc, kg, buz, edt, dig_on, wmode, blank;
  wire  [7:0]  fig;
  wire  [2:0]  prm, ok;
  wire  [1:0]  dig;
  int          n_errors = 0;
  int          n_checks = 0;
  always #25 clk = ~clk;
  cltc_cab_side_model model_u (.clk(clk), .load_set(load_set), .hold_set(hold_set),
    .rel_no({aux_no, ovl_no, cap_no}), .rel_nc({aux_nc, ovl_nc, cap_nc}), .sensor_raw(raw),
    .hold_in(hold), .contact_ok(ok));
  cltc_cab_load_threshold_controller #(.DEB_CYC(4), .BLK_CYC(8), .DBL_CYC(200), .CD_SEC(2)) dut_u (
    .clk(clk), .rst_n(rst_n), .sensor_raw(raw), .hold_in(hold), .key_menu(keys[0]),
    .key_select(keys[1]), .key_modify(keys[2]), .capacity_relay_no(cap_no), .capacity_relay_nc(cap_nc),
    .overload_relay_no(ovl_no), .overload_relay_nc(ovl_nc), .auxiliary_relay_no(aux_no),
    .auxiliary_relay_nc(aux_nc), .figure_seg(fig), .kg_lamp(kg), .buzzer(buz), .disp_param(prm),
    .disp_value(val), .disp_editing(edt), .disp_digit(dig), .disp_digit_on(dig_on),
    .disp_weight_mode(wmode), .disp_blank(blank));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // late sample so edge updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic press(input int k);
    @(posedge clk);
    keys <= 3'h1 << k;
    cyc(10);
    keys <= 3'h0;
    cyc(10);
  endtask
  task automatic setl(input logic [15:0] v);
    @(posedge clk);
    load_set <= v;
    cyc(12);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_trips();
    logic [15:0] w [6] = '{16'd400, 16'd401, 16'd800, 16'd801, 16'd1000, 16'd1001};
    chk("reset relays", 16'h0007, {13'h0, ok} & {13'h0, ~cap_no, ~ovl_no, ~aux_no});
    chk("reset param", 16'h0000, {13'h0, prm});
    chk("reset wmode", 16'h0001, wmode);
    setl(16'd500);
    chk("fig half", 16'h001f, fig);
    for (int i = 0; i < 6; i++) begin
      setl(w[i]);
      chk("aux", i >= 1, aux_no);
      chk("cap", i >= 3, cap_no);
      chk("ovl", i >= 5, ovl_no);
      chk("kg", i >= 4, kg);
      chk("buzzer", i >= 4, buz);
      chk("fig full", i >= 2, &fig);
      chk("contacts", 16'h0007, ok);
    end
    $display("test trips done");
  endtask
  task automatic t_hold();
    setl(16'd500);
    hold_set <= 1'b1;
    setl(16'd1001);
    chk("frozen ovl", 16'h0000, ovl_no);
    for (int i = 0; i < 40 && blank !== 1'b1; i++) cyc(1);
    chk("blink", 16'h0001, blank);
    hold_set <= 1'b0;
    cyc(12);
    chk("resumed ovl", 16'h0001, ovl_no);
    $display("test hold done");
  endtask
  task automatic t_menu();
    for (int i = 1; i <= 5; i++) begin
      press(0);
      chk("param", i % 5, prm);
    end
    $display("test menu done");
  endtask
  task automatic t_edit();
    press(0);
    press(0);
    press(1);
    chk("editing", 16'h0001, edt);
    chk("edit value", 16'd800, val);
    press(2);
    chk("units", 16'd801, val);
    press(1);
    chk("digit", 16'h0001, dig);
    press(2);
    chk("tens", 16'd811, val);
    press(0);
    press(0);
    chk("next param", 16'h0003, prm);
    setl(16'd811);
    chk("cap at 811", 16'h0000, cap_no);
    setl(16'd812);
    chk("cap at 812", 16'h0001, cap_no);
    press(1);
    press(2);
    press(0);
    cyc(250);
    chk("kept param", 16'h0003, prm);
    setl(16'd1001);
    chk("ovl kept", 16'h0001, ovl_no);
    $display("test edit done");
  endtask
  task automatic t_zero();
    press(0);
    press(0);
    setl(16'd100);
    press(1);
    press(0);
    chk("countdown", 16'h0000, wmode);
    for (int i = 0; i < 400 && prm !== 3'h1; i++) cyc(1);
    chk("span shown", 16'h0001, prm);
    setl(16'd100);
    chk("zeroed fig", 16'h0000, fig);
    setl(16'd501);
    chk("aux offset", 16'h0001, aux_no);
    $display("test zero done");
  endtask
  task automatic t_span();
    setl(16'd300);
    press(1);
    press(1);
    press(1);
    press(2);
    chk("span value", 16'd600, val);
    for (int i = 0; i < 40 && dig_on !== 1'b0; i++) cyc(1);
    chk("digit blink", 16'h0000, dig_on);
    press(0);
    press(0);
    chk("span countdown", 16'h0000, wmode);
    for (int i = 0; i < 400 && prm !== 3'h2; i++) cyc(1);
    chk("cap shown", 16'h0002, prm);
    setl(16'd300);
    chk("span load", 16'd600, val);
    setl(16'd200);
    chk("half span", 16'd300, val);
    $display("test span done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(4);
    t_trips();
    t_hold();
    t_menu();
    t_edit();
    t_zero();
    t_span();
    finish_test();
  end
  initial begin
    #5ms;
    n_errors++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
